//--- rtl/ccsc_pkg.sv
// Shared constants and carrier types for the CPU clock source control block
package ccsc_pkg;

    // ****************
    // Register map (byte addresses, one word each)
    // ****************
    localparam logic [7:0] CCSC_OFS_CMC    = 8'h00; // clock_mode_configuration
    localparam logic [7:0] CCSC_OFS_CSC    = 8'h04; // oscillator_stop_control
    localparam logic [7:0] CCSC_OFS_CKC    = 8'h08; // system_clock_selection
    localparam logic [7:0] CCSC_OFS_STAT   = 8'h0c; // block status

    // ****************
    // clock_mode_configuration fields
    // ****************
    localparam int CMC_MAIN_EXT_CLK  = 7; // main_external_clock_select
    localparam int CMC_MAIN_OSC_MODE = 6; // main_oscillator_mode_select
    localparam int CMC_SUB_OSC_MODE  = 4; // sub_oscillator_mode_select
    localparam int CMC_SUB_GAIN_HI   = 2; // sub_amp_gain_hi
    localparam int CMC_SUB_GAIN_LO   = 1; // sub_amp_gain_lo
    localparam int CMC_MAIN_GAIN     = 0; // main_amp_gain
    localparam logic [7:0] CMC_WR_MASK = 8'hd7;
    localparam logic [7:0] CMC_RESET   = 8'h00;

    // ****************
    // oscillator_stop_control fields
    // ****************
    localparam int CSC_MAIN_STOP = 7; // main_oscillator_stop
    localparam int CSC_SUB_STOP  = 6; // sub_oscillator_stop
    localparam int CSC_FAST_STOP = 0; // internal_fast_osc_stop
    localparam logic [7:0] CSC_WR_MASK = 8'hc1;
    localparam logic [7:0] CSC_RESET   = 8'hc0;

    // ****************
    // system_clock_selection fields
    // ****************
    localparam int CKC_SUB_STATUS  = 7; // subsystem_status_flag, read only
    localparam int CKC_SUB_SELECT  = 6; // subsystem_select
    localparam int CKC_MAIN_STATUS = 5; // main_source_status_flag, read only
    localparam int CKC_MAIN_SELECT = 4; // main_clock_select
    localparam int CKC_SUB_DIV     = 3; // subsystem_divider
    localparam int CKC_DIV_HI      = 2; // divider_field_b2
    localparam logic [7:0] CKC_WR_MASK = 8'h5f;
    localparam logic [7:0] CKC_RESET   = 8'h09;

    // ****************
    // Status register fields
    // ****************
    localparam int STAT_SLOW_RUN   = 0;
    localparam int STAT_WDT_OPT    = 1;
    localparam int STAT_FAST20_OK  = 2;
    localparam int STAT_PIN_IN     = 3;
    localparam int STAT_PIN_OUT    = 4;
    localparam int STAT_CMC_LOCKED = 5;

    // ****************
    // Bus constants and divider limits
    // ****************
    localparam logic [2:0] CCSC_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] CCSC_DIV_MAX    = 3'h5; // divide by 32
    localparam int         CCSC_CNT_W      = 5;

    // Clock sources the CPU may run from; the slow internal oscillator is absent
    typedef enum logic [2:0] {
        CCSC_SRC_FAST = 3'b001,
        CCSC_SRC_MAIN = 3'b010,
        CCSC_SRC_SUB  = 3'b100
    } ccsc_src_t;

    // Latched AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] size;
        logic [7:0] addr;
    } ccsc_aphase_t;

    // Option byte values seen by this block
    typedef struct packed {
        logic wdt_enable;   // bit 4 of the option byte
        logic wdt_standby;  // bit 0 of the option byte
        logic fast_1mhz;    // internal fast oscillator strapped to 1 MHz
    } ccsc_opt_t;

endpackage

//--- rtl/ccsc_switch.sv
// Glitch-free CPU clock source switch and divider built on source tick enables
`timescale 1ns/1ps
module ccsc_switch
    import ccsc_pkg::*;
(
    // Clock and reset
    input  wire logic      hclk,
    input  wire logic      hresetn,
    // Source ticks, one cycle each
    input  wire logic      tick_fast,
    input  wire logic      tick_main,
    input  wire logic      tick_sub,
    // Requested source and divider exponent
    input  ccsc_src_t      req_src,
    input  wire logic [2:0] req_div,
    // Results
    output logic           clk_en,
    output ccsc_src_t      act_src
);

    // ****************
    // Helpers
    // ****************
    // Reserved exponents fall back to divide by 32 and stay glitch-free
    function automatic logic [CCSC_CNT_W-1:0] div_limit(input logic [2:0] e);
        logic [2:0] ee;
        ee = (e > CCSC_DIV_MAX) ? CCSC_DIV_MAX : e; // RULE25
        div_limit = CCSC_CNT_W'((32'h1 << ee) - 32'h1);
    endfunction

    function automatic logic pick_tick(input ccsc_src_t s, input logic f,
                                       input logic m, input logic b);
        unique case (s)
            CCSC_SRC_FAST: pick_tick = f;
            CCSC_SRC_MAIN: pick_tick = m;
            CCSC_SRC_SUB:  pick_tick = b;
            default:       pick_tick = 1'b0;
        endcase
    endfunction

    logic [CCSC_CNT_W-1:0] cnt_ff;
    logic [CCSC_CNT_W-1:0] nxt_cnt;
    logic [2:0]            div_ff;
    logic [2:0]            nxt_div;
    ccsc_src_t             src_ff;
    ccsc_src_t             nxt_src;
    logic                  en_ff;
    logic                  nxt_en;
    logic                  tick;

    // ****************
    // Next state
    // ****************
    // Changes of source or ratio only land at the end of a full output
    // period, so no CPU clock pulse is ever shortened
    always_comb begin
        tick    = pick_tick(src_ff, tick_fast, tick_main, tick_sub);
        nxt_cnt = cnt_ff;
        nxt_div = div_ff;
        nxt_src = src_ff;
        nxt_en  = 1'b0;
        if (tick) begin
            if (cnt_ff >= div_limit(div_ff)) begin
                nxt_en  = 1'b1;                   // RULE23
                nxt_cnt = '0;
                nxt_src = req_src;                // RULE24
                nxt_div = req_div;
            end else begin
                nxt_cnt = cnt_ff + CCSC_CNT_W'(1);
            end
        end
    end

    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            div_ff <= 3'h1;
            src_ff <= CCSC_SRC_FAST; // RULE20
            en_ff  <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            src_ff <= nxt_src;
            en_ff  <= nxt_en;
        end
    end

    assign clk_en  = en_ff;
    assign act_src = src_ff; // Status follows the source really in use
endmodule

//--- rtl/ccsc_top.sv
// CPU clock source control: oscillator enables, source select and AHB registers
// Behaviour
// RULE1 - After reset both subsystem pins are plain input ports, not oscillator.
// RULE2 - Mode configuration accepts only its first write, and only as a byte.
// RULE3 - Software sets subsystem mode and all other mode fields in one write.
// RULE4 - Clearing the subsystem stop bit starts the subsystem oscillator.
// RULE5 - Software times subsystem stabilization itself; no hardware counter.
// RULE6 - Subsystem select runs CPU from subsystem clock, undivided or halved.
// RULE7 - Peripherals get the subsystem clock too, except a few own-clocked units.
// RULE8 - Converter and two-wire serial unit are unreliable on the subsystem clock.
// RULE9 - Two read-only flags report the active CPU clock source.
// RULE10 - Setting the subsystem stop bit stops the subsystem oscillator.
// RULE11 - Software checks the flag and halts users before stopping subsystem.
// RULE12 - STOP instruction leaves the subsystem oscillator running.
// RULE13 - Slow internal oscillator can never become the CPU clock.
// RULE14 - Slow oscillator starts after reset and clocks the enabled watchdog.
// RULE15 - While the watchdog runs, nothing in software can stop the slow oscillator.
// RULE16 - Slow oscillator stops on watchdog disabled, or standby without standby watchdog.
// RULE17 - Slow oscillator restarts when that standby mode is released.
// RULE18 - Clock selection resets to 09h, fast internal clock divided by two.
// RULE19 - The 20 MHz internal oscillator is unavailable with the 1 MHz option.
// RULE20 - CPU runs from the fast internal oscillator after reset, no setup.
// RULE21 - Software follows the documented sequence to reach a fast crystal clock.
// RULE22 - Software sets high-speed operation whenever the CPU exceeds 10 MHz.
// RULE23 - Main clock selection divides by 1 to 32 per three-bit field.
// RULE24 - Source switches without short pulses; flags change once switched.
// RULE25 - Prohibited divider settings stay reserved but remain glitch-free.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module ccsc_top
    import ccsc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Oscillator waveforms arriving from the analog side
    input  wire logic        fast_osc_clk,
    input  wire logic        main_osc_clk,
    input  wire logic        sub_osc_clk,
    // Subsystem pins in port mode
    input  wire logic        port_pin_sub_in,
    input  wire logic        port_pin_sub_out,
    // Option byte and CPU standby state, same clock
    input  ccsc_opt_t        opt,
    input  wire logic        cpu_halt,
    input  wire logic        cpu_stop,
    // Oscillator controls
    output logic             sub_pin_osc_mode,
    output logic [1:0]       sub_amp_gain,
    output logic             sub_osc_enable,
    output logic             main_osc_enable,
    output logic             main_ext_clk,
    output logic             main_amp_gain,
    output logic             fast_osc_enable,
    output logic             fast20_allowed,
    output logic             slow_osc_enable,
    // CPU and peripheral clock enables
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             cpu_on_sub,
    output logic             cpu_on_main
);

    // ****************
    // Input synchronisers
    // ****************
    // Oscillator waveforms and pins belong to no clock of ours
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [2:0] osc_last_ff;
    logic [2:0] ticks;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            osc_last_ff <= '0;
        end else begin
            sync1_ff    <= {port_pin_sub_out, port_pin_sub_in,
                            sub_osc_clk, main_osc_clk, fast_osc_clk};
            sync2_ff    <= sync1_ff;
            osc_last_ff <= sync2_ff[2:0];
        end
    end

    // Rising edges give one-cycle source ticks; oscillators must stay below hclk/2
    assign ticks = sync2_ff[2:0] & ~osc_last_ff;

    // ****************
    // Option byte capture
    // ****************
    // Strap is caught by a clocked process in the first cycle after release
    ccsc_opt_t opt_ff;
    ccsc_opt_t nxt_opt;
    logic      opt_done_ff;
    logic      nxt_opt_done;

    always_comb begin
        nxt_opt      = opt_ff;
        nxt_opt_done = 1'b1;
        if (!opt_done_ff) begin
            nxt_opt = opt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_ff      <= '0;
            opt_done_ff <= 1'b0;
        end else begin
            opt_ff      <= nxt_opt;
            opt_done_ff <= nxt_opt_done;
        end
    end

    // ****************
    // AHB-Lite address phase capture
    // ****************
    ccsc_aphase_t ap_ff;
    ccsc_aphase_t nxt_ap;

    always_comb begin
        nxt_ap.valid = hsel & htrans[1] & hready;
        nxt_ap.write = hwrite;
        nxt_ap.size  = hsize;
        nxt_ap.addr  = haddr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_ff <= '0;
        end else begin
            ap_ff <= nxt_ap;
        end
    end

    // ****************
    // Register file
    // ****************
    logic [7:0] cmc_ff;
    logic [7:0] nxt_cmc;
    logic       cmc_lock_ff;
    logic       nxt_cmc_lock;
    logic [7:0] csc_ff;
    logic [7:0] nxt_csc;
    logic [7:0] ckc_ff;
    logic [7:0] nxt_ckc;
    logic       wr_en;
    ccsc_src_t  act_src;

    // Writes land in the data phase; reserved bits are masked off
    always_comb begin
        wr_en        = ap_ff.valid & ap_ff.write;
        nxt_cmc      = cmc_ff;
        nxt_cmc_lock = cmc_lock_ff;
        nxt_csc      = csc_ff;
        nxt_ckc      = ckc_ff;
        if (wr_en) begin
            unique case (ap_ff.addr)
                CCSC_OFS_CMC: begin
                    // Only one byte write ever counts; word writes are ignored
                    if (!cmc_lock_ff && ap_ff.size == CCSC_HSIZE_BYTE) begin // RULE2
                        nxt_cmc      = hwdata[7:0] & CMC_WR_MASK;
                        nxt_cmc_lock = 1'b1;
                    end
                end
                CCSC_OFS_CSC: nxt_csc = hwdata[7:0] & CSC_WR_MASK;
                CCSC_OFS_CKC: nxt_ckc = hwdata[7:0] & CKC_WR_MASK;
                default:      nxt_csc = csc_ff;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmc_ff      <= CMC_RESET;   // RULE1
            cmc_lock_ff <= 1'b0;
            csc_ff      <= CSC_RESET;
            ckc_ff      <= CKC_RESET;   // RULE18
        end else begin
            cmc_ff      <= nxt_cmc;
            cmc_lock_ff <= nxt_cmc_lock;
            csc_ff      <= nxt_csc;
            ckc_ff      <= nxt_ckc;
        end
    end

    // ****************
    // Read path
    // ****************
    // Read data is prepared in the address phase so the slave needs no wait state
    logic [31:0] nxt_rdata;
    logic        slow_en_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  stat;
    logic [7:0]  ckc_view;

    always_comb begin
        ckc_view                  = ckc_ff;
        ckc_view[CKC_SUB_STATUS]  = (act_src == CCSC_SRC_SUB);  // RULE9
        ckc_view[CKC_MAIN_STATUS] = (act_src == CCSC_SRC_MAIN); // RULE9
        stat                      = 8'h00;
        stat[STAT_SLOW_RUN]       = slow_en_ff;
        stat[STAT_WDT_OPT]        = opt_ff.wdt_enable;
        stat[STAT_FAST20_OK]      = ~opt_ff.fast_1mhz;
        // Pins read as ports only while not handed to the oscillator
        stat[STAT_PIN_IN]         = sync2_ff[3] & ~cmc_ff[CMC_SUB_OSC_MODE];
        stat[STAT_PIN_OUT]        = sync2_ff[4] & ~cmc_ff[CMC_SUB_OSC_MODE];
        stat[STAT_CMC_LOCKED]     = cmc_lock_ff;
        nxt_rdata                 = rdata_ff;
        if (nxt_ap.valid && !hwrite) begin
            unique case (haddr)
                CCSC_OFS_CMC:  nxt_rdata = {24'h0, cmc_ff};
                CCSC_OFS_CSC:  nxt_rdata = {24'h0, csc_ff};
                CCSC_OFS_CKC:  nxt_rdata = {24'h0, ckc_view};
                CCSC_OFS_STAT: nxt_rdata = {24'h0, stat};
                default:       nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************
    // Oscillator control
    // ****************
    logic       nxt_slow_en;
    logic [8:0] osc_ff;
    logic [8:0] nxt_osc;
    logic       standby;

    // Slow oscillator has no software control at all, so a runaway loop
    // cannot starve the watchdog
    always_comb begin
        standby     = cpu_halt | cpu_stop;
        nxt_slow_en = opt_ff.wdt_enable                          // RULE14 RULE15
                      & ~(standby & ~opt_ff.wdt_standby);        // RULE16 RULE17
        nxt_osc[0]  = cmc_ff[CMC_SUB_OSC_MODE];                  // RULE1
        nxt_osc[1]  = cmc_ff[CMC_SUB_OSC_MODE]
                      & ~csc_ff[CSC_SUB_STOP];                   // RULE4 RULE10 RULE12
        nxt_osc[2]  = cmc_ff[CMC_MAIN_OSC_MODE]
                      & ~csc_ff[CSC_MAIN_STOP] & ~cpu_stop;
        nxt_osc[3]  = cmc_ff[CMC_MAIN_EXT_CLK];
        nxt_osc[4]  = cmc_ff[CMC_MAIN_GAIN];
        nxt_osc[5]  = ~csc_ff[CSC_FAST_STOP] & ~cpu_stop;
        nxt_osc[6]  = ~opt_ff.fast_1mhz & opt_done_ff;           // RULE19
        nxt_osc[8:7] = {cmc_ff[CMC_SUB_GAIN_HI], cmc_ff[CMC_SUB_GAIN_LO]};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_en_ff <= 1'b0;
            osc_ff     <= 9'h020; // Fast internal oscillator alone runs out of reset
        end else begin
            slow_en_ff <= nxt_slow_en;
            osc_ff     <= nxt_osc;
        end
    end

    // ****************
    // Source selection and divider
    // ****************
    // Subsystem select wins over main select; the slow oscillator has no code
    ccsc_src_t  req_src;
    logic [2:0] req_div;
    logic       clk_en;

    always_comb begin
        if (ckc_ff[CKC_SUB_SELECT]) begin
            req_src = CCSC_SRC_SUB;                          // RULE6 RULE13
            req_div = {2'b00, ckc_ff[CKC_SUB_DIV]};          // RULE6
        end else if (ckc_ff[CKC_MAIN_SELECT]) begin
            req_src = CCSC_SRC_MAIN;
            req_div = ckc_ff[CKC_DIV_HI:0];                  // RULE23
        end else begin
            req_src = CCSC_SRC_FAST;
            req_div = ckc_ff[CKC_DIV_HI:0];
        end
    end

    ccsc_switch u_switch (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .tick_fast (ticks[0]),
        .tick_main (ticks[1]),
        .tick_sub  (ticks[2]),
        .req_src   (req_src),
        .req_div   (req_div),
        .clk_en    (clk_en),
        .act_src   (act_src)
    );

    // ****************
    // Outputs
    // ****************
    // Peripherals share the CPU enable; own-clocked units take other clocks
    assign hrdata           = rdata_ff;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign sub_pin_osc_mode = osc_ff[0];
    assign sub_osc_enable   = osc_ff[1];
    assign main_osc_enable  = osc_ff[2];
    assign main_ext_clk     = osc_ff[3];
    assign main_amp_gain    = osc_ff[4];
    assign fast_osc_enable  = osc_ff[5];
    assign fast20_allowed   = osc_ff[6];
    assign sub_amp_gain     = osc_ff[8:7];
    assign slow_osc_enable  = slow_en_ff;
    assign cpu_clk_en       = clk_en;
    assign periph_clk_en    = clk_en;  // RULE7
    assign cpu_on_sub       = (act_src == CCSC_SRC_SUB);
    assign cpu_on_main      = (act_src == CCSC_SRC_MAIN);
endmodule

//--- tb/ccsc_osc_model.sv
// Behavioural oscillators and crystal that feed the clock source control block
`timescale 1ns/1ps
module ccsc_osc_model (
    // Enables from the block
    input  wire logic fast_en,
    input  wire logic main_en,
    input  wire logic sub_en,
    // Oscillator waveforms
    output logic      fast_clk,
    output logic      main_clk,
    output logic      sub_clk
);
    // ****************
    // Waveforms
    // ****************
    // A stopped oscillator stands low; periods are four bus cycles or more
    initial begin
        fast_clk = 1'b0;
        main_clk = 1'b0;
        sub_clk  = 1'b0;
    end
    always #20 fast_clk = fast_en ? ~fast_clk : 1'b0;
    always #20 main_clk = main_en ? ~main_clk : 1'b0;
    always #40 sub_clk  = sub_en ? ~sub_clk : 1'b0;
endmodule

//--- tb/ccsc_chk.sv
// Concurrent checks on the ports of the clock source control block
`timescale 1ns/1ps
module ccsc_chk
    import ccsc_pkg::*;
(
    // Clock, reset and inputs
    input wire logic hclk,
    input wire logic hresetn,
    input ccsc_opt_t opt,
    input wire logic cpu_halt,
    input wire logic cpu_stop,
    // Outputs watched
    input wire logic sub_pin_osc_mode,
    input wire logic sub_osc_enable,
    input wire logic fast20_allowed,
    input wire logic slow_osc_enable,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic cpu_on_sub,
    input wire logic cpu_on_main
);
    // ****************
    // Warm-up counter: option byte is only valid from the second edge
    // ****************
    logic [1:0] up_ff;
    logic [1:0] nxt_up;
    always_comb nxt_up = (up_ff == 2'h2) ? up_ff : up_ff + 2'h1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) up_ff <= 2'h0;
        else up_ff <= nxt_up;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence warm_s; up_ff == 2'h2; endsequence
    sequence sby_enter_s; warm_s ##0 (opt.wdt_enable && !opt.wdt_standby && cpu_halt); endsequence
    sequence sby_leave_s; warm_s ##0 (opt.wdt_enable && $fell(cpu_halt) && !cpu_stop); endsequence
    // ****************
    // Assertions
    // ****************
    clk_pair_a: assert property (cpu_clk_en == periph_clk_en)
        else $error("cpu and peripheral enables differ");
    src_excl_a: assert property (!(cpu_on_sub && cpu_on_main))
        else $error("two sources flagged at once");
    pins_port_a: assert property (up_ff != 2'h2 |-> !sub_pin_osc_mode && !sub_osc_enable)
        else $error("subsystem pins not in port mode after reset");
    fast_first_a: assert property (up_ff != 2'h2 |-> !cpu_on_sub && !cpu_on_main)
        else $error("cpu not on fast internal clock after reset");
    sub_mode_a: assert property (sub_osc_enable |-> sub_pin_osc_mode)
        else $error("subsystem oscillator on in port mode");
    stop_keep_a: assert property ($rose(cpu_stop) && sub_osc_enable |=> sub_osc_enable)
        else $error("stop instruction halted subsystem oscillator");
    wdt_keep_a: assert property (warm_s ##0 (opt.wdt_enable && opt.wdt_standby) |=> slow_osc_enable)
        else $error("slow oscillator stopped with watchdog running");
    sby_stop_a: assert property (sby_enter_s |=> !slow_osc_enable)
        else $error("slow oscillator kept in standby");
    wdt_off_a: assert property (warm_s ##0 !opt.wdt_enable |-> !slow_osc_enable)
        else $error("slow oscillator runs with watchdog disabled");
    sby_wake_a: assert property (sby_leave_s |=> slow_osc_enable)
        else $error("slow oscillator not restarted after standby");
    fast20_a: assert property (warm_s |-> fast20_allowed == !opt.fast_1mhz)
        else $error("fast oscillator availability wrong");
endmodule
bind ccsc_top ccsc_chk u_chk (.hclk, .hresetn, .opt, .cpu_halt, .cpu_stop, .sub_pin_osc_mode,
    .sub_osc_enable, .fast20_allowed, .slow_osc_enable, .cpu_clk_en, .periph_clk_en,
    .cpu_on_sub, .cpu_on_main);

//--- tb/ccsc_top_tb_top.sv
// Register-level testbench for the clock source control block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module ccsc_top_tb_top;
    import ccsc_pkg::*;
    logic        hclk, hresetn, hwrite, cpu_halt, cpu_stop, pin_in, pin_out, hreadyout, hresp;
    logic        sub_mode, sub_en, main_en, fast_en, f20, slow_en, clk_en, on_sub, on_main;
    logic        fclk, mclk, sclk, ext, amp;
    logic [1:0]  htrans, gain;
    logic [2:0]  hsize;
    logic [7:0]  haddr;
    logic [31:0] hwdata, hrdata, rd;
    ccsc_opt_t   opt;
    int          n_mismatch, compares, n;
    ccsc_top uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fast_osc_clk(fclk), .main_osc_clk(mclk),
        .sub_osc_clk(sclk), .port_pin_sub_in(pin_in), .port_pin_sub_out(pin_out), .opt, .cpu_halt,
        .cpu_stop, .sub_pin_osc_mode(sub_mode), .sub_amp_gain(gain), .sub_osc_enable(sub_en),
        .main_osc_enable(main_en), .main_ext_clk(ext), .main_amp_gain(amp),
        .fast_osc_enable(fast_en),
        .fast20_allowed(f20), .slow_osc_enable(slow_en), .cpu_clk_en(clk_en), .periph_clk_en(),
        .cpu_on_sub(on_sub), .cpu_on_main(on_main));
    ccsc_osc_model xtal (.fast_en, .main_en, .sub_en, .fast_clk(fclk), .main_clk(mclk),
        .sub_clk(sclk));
    // ****************
    // Clock, verdict and bus tasks
    // ****************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic finish_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic tmo();
        n_mismatch++;
        finish_test();
    endtask
    // Bounded wait for hready; the bus never stalls but the master assumes nothing
    task automatic hrdy();
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) tmo();
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [2:0] sz,
                        input logic [31:0] wd);
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= 2'h2;
        hrdy();
        htrans <= 2'h0;
        hwdata <= wd;
        hrdy();
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 3'h2, 32'h0);
        `CHK({hresp, rd}, {1'b0, e})
    endtask
    // Cycles from the previous enable pulse to the next one
    task automatic wp();
        n = 0;
        do begin @(posedge hclk); n++; end while (clk_en !== 1'b1 && n < 300);
        if (n >= 300) tmo();
    endtask
    task automatic gap(input int e);
        repeat (4) wp();
        `CHK(n, e)
    endtask
    task automatic wsrc(input logic s, input logic m);
        for (n = 0; (on_sub !== s || on_main !== m) && n < 500; n++) @(posedge hclk);
        if (n >= 500) tmo();
    endtask
    task automatic do_reset(input ccsc_opt_t o);
        hresetn <= 1'b0;
        opt <= o;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        {hresetn, hwrite, cpu_halt, cpu_stop, pin_out, htrans, hsize, haddr, hwdata} = '0;
        {n_mismatch, compares, pin_in, opt} = {64'h0, 1'b1, 3'b110};
        do_reset(3'b110);
        rchk(8'h08, 32'h09);
        rchk(8'h04, 32'hc0);
        rchk(8'h0c, 32'h0f);
        gap(8);
        rchk(8'h10, 32'h0);
        xfer(8'h00, 1'b1, 3'h2, 32'h50);
        rchk(8'h00, 32'h0);
        xfer(8'h00, 1'b1, 3'h0, 32'h57);
        xfer(8'h00, 1'b1, 3'h0, 32'h10);
        rchk(8'h00, 32'h57);
        `CHK({ext, amp, gain}, 4'h7)
        xfer(8'h04, 1'b1, 3'h2, 32'h0);
        rchk(8'h04, 32'h0);
        `CHK(sub_en, 1'b1)
        repeat (100) @(posedge hclk);
        for (int s = 0; s < 2; s++) begin
            xfer(8'h08, 1'b1, 3'h2, 32'h40 | (s << 3));
            wsrc(1'b1, 1'b0);
            rchk(8'h08, 32'hc0 | (s << 3));
            gap(8 << s);
        end
        cpu_stop <= 1'b1;
        repeat (4) @(posedge hclk);
        `CHK({sub_en, main_en, fast_en}, 3'b100)
        cpu_stop <= 1'b0;
        for (int d = 0; d < 7; d++) begin
            xfer(8'h08, 1'b1, 3'h2, 32'h10 | d);
            wsrc(1'b0, 1'b1);
            rchk(8'h08, 32'h30 | d);
            gap(4 << (d > 5 ? 5 : d));
        end
        xfer(8'h08, 1'b1, 3'h2, 32'h0);
        wsrc(1'b0, 1'b0);
        rchk(8'h08, 32'h0);
        xfer(8'h04, 1'b1, 3'h2, 32'h40);
        rchk(8'h04, 32'h40);
        `CHK(sub_en, 1'b0)
        do_reset(3'b101);
        rchk(8'h00, 32'h0);
        `CHK(f20, 1'b0)
        cpu_halt <= 1'b1;
        repeat (3) @(posedge hclk);
        `CHK(slow_en, 1'b0)
        cpu_halt <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK(slow_en, 1'b1)
        do_reset(3'b010);
        rchk(8'h0c, 32'h0c);
        finish_test();
    end
endmodule
